// ==== inc/cfg_port_pkg.sv ====
// Shared constants for the serial configuration port.
`default_nettype none
package cfg_port_pkg;
	localparam int          WORD_BITS     = 16;
	localparam int          ADDR_BITS     = 7;
	localparam int          DATA_BITS     = 8;
	localparam int          CNT_W         = 5;
	localparam logic [4:0]  DATA_START    = 5'h08;
	localparam logic [4:0]  WORD_LEN      = 5'h10;
	localparam logic [6:0]  ADDR_RESET    = 7'h00;
	localparam logic [6:0]  ADDR_POWER    = 7'h01;
	localparam logic [6:0]  ADDR_TIMING   = 7'h02;
	localparam logic [6:0]  ADDR_OUTMODE  = 7'h03;
	localparam logic [7:0]  REG_RESET_VAL = 8'h00;
	localparam int          RESET_BIT     = 7;
	localparam int          PWR_MSB       = 1;
	localparam int          PWR_LSB       = 0;
	localparam int          INV_BIT       = 3;
	localparam int          PHASE_MSB     = 2;
	localparam int          PHASE_LSB     = 1;
	localparam int          DCS_BIT       = 0;
	localparam int          CUR_MSB       = 6;
	localparam int          CUR_LSB       = 4;
	localparam int          TERM_BIT      = 3;
	localparam int          HIZ_BIT       = 2;
	localparam int          FMT_MSB       = 1;
	localparam int          FMT_LSB       = 0;
	localparam logic [1:0]  PWR_NORMAL    = 2'h0;
	localparam logic [1:0]  PWR_NAP       = 2'h1;
	localparam logic [1:0]  PWR_SLEEP     = 2'h3;
	localparam logic [2:0]  CUR_UNUSED    = 3'h3;
	// Serial clock divider for the host: half period in system clocks (80 ns period).
	localparam int          SCK_HALF      = 5;
endpackage : cfg_port_pkg
`default_nettype wire

// ==== inc/cfg_link_if.sv ====
// Serial link between the host and the device, with the open-drain data out wire.
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo_o;
	logic sdo_oe;
	logic sdo;
	// Open-drain line with a pull-up: low only while the device pulls.
	assign sdo = (sdo_oe && !sdo_o) ? 1'b0 : 1'b1;
	modport device (input cs_n, input sck, input sdi, output sdo_o, output sdo_oe);
	modport host (output cs_n, output sck, output sdi, input sdo);
endinterface : cfg_link_if
`default_nettype wire

// ==== rtl/cfg_port_device.sv ====
// Device end: serial register port and mode control register bank.
`timescale 1ns/1ps
`default_nettype none
module cfg_port_device
	import cfg_port_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       prog_mode_select_i,
	cfg_link_if.device      link,
	output logic [1:0]      power_state_field_o,
	output logic            nap_o,
	output logic            sleep_o,
	output logic            out_clock_invert_o,
	output logic [1:0]      out_clock_phase_sel_o,
	output logic            duty_stabilizer_en_o,
	output logic [2:0]      driver_current_sel_o,
	output logic            internal_term_en_o,
	output logic            outputs_hiz_o,
	output logic [1:0]      output_format_sel_o,
	output logic            phase_without_dcs_o
);
	// Pin copies: two flops each, and a third on the serial clock to find its edges.
	logic [1:0] cs_sync_q;
	logic [2:0] sck_sync_q;
	logic [1:0] sdi_sync_q;
	logic       mode_sync_q;
	logic       mode_q;

	// Frame state, cleared whenever the port is not selected.
	logic [CNT_W-1:0] bit_cnt_q;
	logic [WORD_BITS-2:0] shift_q;
	logic       rd_q;
	logic [DATA_BITS-1:0] rd_shift_q;

	// Mode control register bank.
	logic [DATA_BITS-1:0] power_q;
	logic [DATA_BITS-1:0] timing_q;
	logic [DATA_BITS-1:0] outmode_q;
	logic       sdo_drive_q;
	logic       sdo_oe_q;
	logic       active;
	logic       sck_rise;
	logic       sck_fall;
	logic       sample;
	logic       word_done;
	logic [ADDR_BITS-1:0] addr_w;
	logic [DATA_BITS-1:0] data_w;
	logic [DATA_BITS-1:0] rd_val;

	// Stage one of each synchroniser feeds only stage two.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cs_sync_q   <= 2'h3;
			sck_sync_q  <= 3'h0;
			sdi_sync_q  <= 2'h0;
			mode_sync_q <= 1'b1;
			mode_q      <= 1'b1;
		end else begin
			cs_sync_q   <= {cs_sync_q[0], link.cs_n};
			sck_sync_q  <= {sck_sync_q[1:0], link.sck};
			sdi_sync_q  <= {sdi_sync_q[0], link.sdi};
			mode_sync_q <= prog_mode_select_i;
			mode_q      <= mode_sync_q;
		end
	end

	// Every decision lags the pins by about three clocks; the host's half period
	// of five clocks leaves room for that.
	assign active    = !mode_q && !cs_sync_q[1];
	assign sck_rise  = sck_sync_q[1] && !sck_sync_q[2];
	assign sck_fall  = !sck_sync_q[1] && sck_sync_q[2];
	assign sample    = active && sck_rise && (bit_cnt_q < WORD_LEN);
	// A frame cut short before its sixteenth bit changes no register.
	assign word_done = sample && (bit_cnt_q == WORD_LEN - 5'h01);
	// Full word once the last bit arrives: flag, address, data, MSB first.
	assign addr_w    = shift_q[DATA_BITS+ADDR_BITS-2:DATA_BITS-1];
	assign data_w    = {shift_q[DATA_BITS-2:0], sdi_sync_q[1]};

	always_ff @(posedge clock_i) begin
		if (rst_i || !active) begin
			bit_cnt_q <= '0;
			shift_q   <= '0;
		end else if (sample) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			shift_q   <= {shift_q[WORD_BITS-3:0], sdi_sync_q[1]};
		end
	end

	// Read flag latched after the first bit; the read data is fetched after the eighth.
	always_ff @(posedge clock_i) begin
		if (rst_i || !active) begin
			rd_q <= 1'b0;
		end else if (sample && bit_cnt_q == 5'h00) begin
			rd_q <= sdi_sync_q[1];
		end
	end

	// Register 00h and unmapped addresses read back as zero, so the reset bit never shows.
	always_comb begin
		unique case ({shift_q[ADDR_BITS-2:0], sdi_sync_q[1]})
			ADDR_POWER:   rd_val = power_q;
			ADDR_TIMING:  rd_val = timing_q;
			ADDR_OUTMODE: rd_val = outmode_q;
			default:      rd_val = REG_RESET_VAL;
		endcase
	end

	// Each bit changes just after a falling edge and stands for a whole serial period;
	// the host takes it at the next falling edge, just before it moves on.
	always_ff @(posedge clock_i) begin
		if (rst_i || !active) begin
			rd_shift_q  <= '0;
			sdo_drive_q <= 1'b1;
			sdo_oe_q    <= 1'b0;
		end else if (sample && bit_cnt_q == DATA_START - 5'h01 && rd_q) begin
			rd_shift_q  <= rd_val;
		end else if (sck_fall && rd_q && bit_cnt_q >= DATA_START && bit_cnt_q <= WORD_LEN) begin
			if (bit_cnt_q == WORD_LEN) begin
				sdo_oe_q <= 1'b0;
			end else begin
				sdo_drive_q <= rd_shift_q[DATA_BITS-1];
				sdo_oe_q    <= !rd_shift_q[DATA_BITS-1];
				rd_shift_q  <= {rd_shift_q[DATA_BITS-2:0], 1'b0};
			end
		end
	end

	assign link.sdo_o  = sdo_drive_q;
	assign link.sdo_oe = sdo_oe_q;

	// Software reset takes one cycle, so its bit never reads back as one.
	// A read never reaches this process, so the addressed register keeps its value.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			power_q   <= REG_RESET_VAL;
			timing_q  <= REG_RESET_VAL;
			outmode_q <= REG_RESET_VAL;
		end else if (word_done && !rd_q) begin
			unique case (addr_w)
				ADDR_RESET: begin
					if (data_w[RESET_BIT]) begin
						power_q   <= REG_RESET_VAL;
						timing_q  <= REG_RESET_VAL;
						outmode_q <= REG_RESET_VAL;
					end
				end
				ADDR_POWER:   power_q   <= data_w;
				ADDR_TIMING:  timing_q  <= data_w;
				ADDR_OUTMODE: outmode_q <= data_w;
				default: ;
			endcase
		end
	end

	// One more register stage so that every output pin comes straight from a flip-flop.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			power_state_field_o   <= PWR_NORMAL;
			nap_o                 <= 1'b0;
			sleep_o               <= 1'b0;
			out_clock_invert_o    <= 1'b0;
			out_clock_phase_sel_o <= 2'h0;
			duty_stabilizer_en_o  <= 1'b0;
			driver_current_sel_o  <= 3'h0;
			internal_term_en_o    <= 1'b0;
			outputs_hiz_o         <= 1'b0;
			output_format_sel_o   <= 2'h0;
			phase_without_dcs_o   <= 1'b0;
		end else begin
			power_state_field_o   <= power_q[PWR_MSB:PWR_LSB];
			nap_o                 <= power_q[PWR_MSB:PWR_LSB] == PWR_NAP;
			sleep_o               <= power_q[PWR_MSB:PWR_LSB] == PWR_SLEEP;
			out_clock_invert_o    <= timing_q[INV_BIT];
			out_clock_phase_sel_o <= timing_q[PHASE_MSB:PHASE_LSB];
			duty_stabilizer_en_o  <= timing_q[DCS_BIT];
			// Unused current code falls back to the default current.
			driver_current_sel_o  <= (outmode_q[CUR_MSB:CUR_LSB] == CUR_UNUSED) ?
				3'h0 : outmode_q[CUR_MSB:CUR_LSB];
			internal_term_en_o    <= outmode_q[TERM_BIT];
			outputs_hiz_o         <= outmode_q[HIZ_BIT];
			output_format_sel_o   <= outmode_q[FMT_MSB:FMT_LSB];
			// Flags a host that breaks the stabilizer requirement.
			phase_without_dcs_o   <= (timing_q[PHASE_MSB:PHASE_LSB] != 2'h0) &&
				!timing_q[DCS_BIT];
		end
	end

endmodule : cfg_port_device
`default_nettype wire

// ==== rtl/cfg_port_host.sv ====
// Host end: serial master that sends one 16-bit command per request.
`timescale 1ns/1ps
`default_nettype none
module cfg_port_host
	import cfg_port_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic       rd_i,
	input  wire logic [6:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic            busy_o,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	cfg_link_if.host        link
);
	typedef enum logic [1:0] {IDLE, SHIFT, FINISH} hstate_e;
	hstate_e state_q;
	logic [3:0] div_q;
	logic [CNT_W-1:0] bit_q;
	logic [WORD_BITS-1:0] word_q;
	logic [DATA_BITS-1:0] rd_q;
	logic [1:0] sdo_sync_q;
	logic cs_n_q;
	logic sck_q;
	logic sdi_q;
	logic tick;

	assign tick = (div_q == 4'(SCK_HALF - 1));

	always_ff @(posedge clock_i) begin
		if (rst_i || state_q == IDLE) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? 4'h0 : div_q + 4'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sdo_sync_q <= 2'h3;
		end else begin
			sdo_sync_q <= {sdo_sync_q[0], link.sdo};
		end
	end

	// The first command after power-up must be a software reset write; the user issues it.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= IDLE;
			cs_n_q  <= 1'b1;
			sck_q   <= 1'b0;
			sdi_q   <= 1'b0;
			bit_q   <= '0;
			word_q  <= '0;
			rd_q    <= '0;
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			rdata_o <= '0;
		end else begin
			done_o <= 1'b0;
			unique case (state_q)
				IDLE: begin
					if (req_i) begin
						word_q  <= {rd_i, addr_i, wdata_i};
						cs_n_q  <= 1'b0;
						sdi_q   <= rd_i;
						bit_q   <= '0;
						busy_o  <= 1'b1;
						state_q <= SHIFT;
					end
				end
				SHIFT: begin
					if (tick) begin
						sck_q <= !sck_q;
						if (!sck_q) begin
							bit_q <= bit_q + 5'h01;
						end else begin
							// The device moves its bit a few clocks after a fall and the
							// bit needs two more clocks through the synchroniser, so it is
							// taken at the next fall, where it has stood for most of a period.
							rd_q <= {rd_q[DATA_BITS-2:0], sdo_sync_q[1]};
							if (bit_q == WORD_LEN) begin
								state_q <= FINISH;
							end else begin
								word_q <= {word_q[WORD_BITS-2:0], 1'b0};
								sdi_q  <= word_q[WORD_BITS-2];
							end
						end
					end
				end
				FINISH: begin
					if (tick) begin
						cs_n_q  <= 1'b1;
						busy_o  <= 1'b0;
						done_o  <= 1'b1;
						rdata_o <= rd_q;
						state_q <= IDLE;
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sck  = sck_q;
	assign link.sdi  = sdi_q;
endmodule : cfg_port_host
`default_nettype wire

// ==== testbench/cfg_link_sva.sv ====
// Concurrent checks on the serial link between the host and the device ends.
`timescale 1ns/1ps
`default_nettype none
module cfg_link_sva (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_oe
);
	logic [4:0] rise_q;
	logic       sck_q;
	logic       rd_q;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clock_i) begin
		sck_q <= sck;
	end
	// Rises are counted in helper logic so that a frame of any length below 48 rises is caught.
	always_ff @(posedge clock_i) begin
		if (rst_i || cs_n) begin
			rise_q <= 5'h00;
		end else if (sck && !sck_q) begin
			rise_q <= rise_q + 5'h01;
		end
	end
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rd_q <= 1'b0;
		end else if (!cs_n && sck && !sck_q && rise_q == 5'h00) begin
			rd_q <= sdi;
		end
	end
	a_idle_clock_low: assert property (cs_n |-> !sck)
		else $error("serial clock moved outside a frame");
	a_cs_lead_time: assert property ($fell(cs_n) |-> !sck [*4])
		else $error("serial clock rose too soon after select");
	a_frame_sixteen: assert property ($rose(cs_n) |-> rise_q == 5'h10)
		else $error("frame did not carry sixteen clock rises");
	a_sck_high_len: assert property ($rose(sck) |-> sck [*5] ##1 !sck)
		else $error("serial clock high time wrong");
	a_sdi_steady: assert property (sck && sck_q |-> $stable(sdi))
		else $error("serial input moved while clock high");
	a_read_window: assert property (sdo_oe |-> !cs_n && rise_q >= 5'h08)
		else $error("serial output driven outside the data half");
	a_read_only: assert property (sdo_oe |-> rd_q)
		else $error("serial output driven during a write");
	a_release_end: assert property ($rose(cs_n) |-> !sdo_oe ##1 !sdo_oe)
		else $error("serial output not released after frame");
endmodule : cfg_link_sva
`default_nettype wire

// ==== testbench/adc_serial_config_port_tb.sv ====
// Testbench joining host and device ends across the serial link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module adc_serial_config_port_tb;
	import cfg_port_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        mode_sel = 1'b0;
	logic        req = 1'b0;
	logic        rd = 1'b0;
	logic [6:0]  addr = 7'h00;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        busy, done, nap, sleep, inv, duty_stabilizer_en, term, hiz, pwd;
	logic [1:0]  pwr, phase, fmt;
	logic [2:0]  cur;
	logic [15:0] outs;
	int          n_errors = 0;
	int          checked = 0;
	assign outs = {pwr, nap, sleep, inv, phase, duty_stabilizer_en, cur, term, hiz, fmt, pwd};
	cfg_link_if link ();
	cfg_port_host i_cfg_port_host (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .rd_i(rd),
		.addr_i(addr), .wdata_i(wdata), .busy_o(busy), .done_o(done), .rdata_o(rdata),
		.link(link));
	cfg_port_device i_cfg_port_device (.clock_i(clock_i), .rst_i(rst_i),
		.prog_mode_select_i(mode_sel), .link(link), .power_state_field_o(pwr), .nap_o(nap),
		.sleep_o(sleep), .out_clock_invert_o(inv), .out_clock_phase_sel_o(phase),
		.duty_stabilizer_en_o(duty_stabilizer_en), .driver_current_sel_o(cur), .internal_term_en_o(term),
		.outputs_hiz_o(hiz), .output_format_sel_o(fmt), .phase_without_dcs_o(pwd));
	cfg_link_sva i_cfg_link_sva (.clock_i(clock_i), .rst_i(rst_i), .cs_n(link.cs_n),
		.sck(link.sck), .sdi(link.sdi), .sdo_oe(link.sdo_oe));
	always #4 clock_i = ~clock_i;
	task automatic close_out;
		if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// Done is sampled on the falling edge so it never races the edge that sets it.
	task automatic cmd(input logic r, input logic [6:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		req <= 1'b1;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clock_i);
		req <= 1'b0;
		@(negedge clock_i);
		`CHK("busy", 1'b1, busy)
		`CHK("cs_n", 1'b0, link.cs_n)
		do begin @(negedge clock_i); n++; end while (done !== 1'b1 && n < 400);
		if (n >= 400) `CHK("done", 1'b1, 1'b0)
		`CHK("busy", 1'b0, busy)
		`CHK("cs_n", 1'b1, link.cs_n)
		repeat (4) @(posedge clock_i);
	endtask : cmd
	task automatic wr_rd(input logic [6:0] a, input logic [7:0] d);
		cmd(1'b0, a, d);
		cmd(1'b1, a, 8'hff);
		`CHK("readback", d, rdata)
	endtask : wr_rd
	task automatic t_zero;
		`CHK("outs", 16'h0000, outs)
		for (int a = 0; a < 4; a++) begin
			cmd(1'b1, 7'(a), 8'h00);
			`CHK("reg", 8'h00, rdata)
		end
	endtask : t_zero
	task automatic t_power;
		for (int c = 0; c < 4; c++) begin
			wr_rd(ADDR_POWER, 8'(c));
			`CHK("pwr", 2'(c), pwr)
			`CHK("nap", c == 1, nap)
			`CHK("sleep", c == 3, sleep)
		end
	endtask : t_power
	task automatic t_timing;
		logic [1:0] p;
		for (int c = 0; c < 4; c++) begin
			p = 2'(c);
			wr_rd(ADDR_TIMING, {4'h0, p[0], p, p[1]});
			`CHK("inv", p[0], inv)
			`CHK("phase", p, phase)
			`CHK("dcs", p[1], duty_stabilizer_en)
			`CHK("pwd", p == 2'h1, pwd)
		end
	endtask : t_timing
	task automatic t_outmode;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			cmd(1'b0, ADDR_OUTMODE, {1'b0, c, c[0], c[1], c[1:0]});
			`CHK("cur", (c == CUR_UNUSED) ? 3'h0 : c, cur)
			`CHK("term", c[0], term)
			`CHK("hiz", c[1], hiz)
			`CHK("fmt", c[1:0], fmt)
		end
	endtask : t_outmode
	// Reads, parallel mode and unmapped writes must all leave the bank untouched.
	task automatic t_refused;
		wr_rd(ADDR_TIMING, 8'h09);
		`CHK("inv", 1'b1, inv)
		mode_sel <= 1'b1;
		cmd(1'b0, ADDR_TIMING, 8'h00);
		`CHK("inv", 1'b1, inv)
		mode_sel <= 1'b0;
		cmd(1'b0, 7'h05, 8'h5a);
		cmd(1'b1, 7'h05, 8'h00);
		`CHK("unmapped", 8'h00, rdata)
		cmd(1'b1, ADDR_TIMING, 8'h00);
		`CHK("timing", 8'h09, rdata)
	endtask : t_refused
	initial begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		cmd(1'b0, ADDR_RESET, 8'h80);
		t_zero();
		t_power();
		t_timing();
		t_outmode();
		t_refused();
		cmd(1'b0, ADDR_RESET, 8'h80);
		t_zero();
		close_out();
	end
	initial begin
		repeat (30000) @(posedge clock_i);
		n_errors++;
		close_out();
	end
endmodule : adc_serial_config_port_tb
`default_nettype wire
